// *** rtl/ook_receiver.sv ***
// Purpose: Low-side receiver recovering a bit from carrier activity
// Assumes: carrier toggles at least every CARRIER_HALF cycles for a one
// Notes: Edge seen within loss window reads as one
`timescale 1ns/1ps
module ook_receiver
  import trip_pkg::*;
#(
  parameter int LOSS = CARRIER_LOSS
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic carrier,
  output logic bit_out
);
  initial begin
    if (LOSS < CARRIER_HALF + 1 || LOSS > 255) begin
      $error("LOSS out of range");
    end
  end
  logic sync1_q, sync2_q, prev_q, bit_q, bit_d;
  logic [7:0] idle_q, idle_d;
  always_comb begin
    idle_d = idle_q;
    bit_d = bit_q;
    if (sync2_q != prev_q) begin
      idle_d = 8'h00;
      bit_d = 1'b1;
    end else if (idle_q >= 8'(LOSS)) begin
      bit_d = 1'b0;
    end else begin
      idle_d = idle_q + 8'h01;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
      idle_q <= 8'h00;
      bit_q <= 1'b0;
    end else if (clk_en) begin
      sync1_q <= carrier;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
      idle_q <= idle_d;
      bit_q <= bit_d;
    end
  end
  assign bit_out = bit_q;
endmodule : ook_receiver

// *** rtl/trip_latch.sv ***
// Purpose: Trip decision, OOK link and open-drain alarm with latch
// Assumes: levels are synchronous mV codes; hold_ctrl synchronous
// Notes: alarm_oe high means the pin is pulled low
`timescale 1ns/1ps
module trip_latch
  import trip_pkg::*;
#(
  parameter int CLEAR_CNT = CLEAR_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [LEVEL_W-1:0] input_level,
  input wire logic [LEVEL_W-1:0] reference_level,
  input wire logic input_negative,
  input wire logic hold_ctrl,
  output logic alarm_o,
  output logic alarm_oe,
  output logic trip_state,
  output logic high_hyst_mode,
  output logic latched
);
  initial begin
    if (CLEAR_CNT < 1 || CLEAR_CNT > 65535) begin
      $error("CLEAR_CNT out of range");
    end
    // Phase counter is two bits wide
    if (CARRIER_HALF < 1 || CARRIER_HALF > 4) begin
      $error("CARRIER_HALF out of range");
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // High side: mode, hysteresis, trip decision
  logic high_mode;
  logic [LEVEL_W:0] trip_level, release_level;
  logic positive_comparator_q, positive_comparator_d;
  logic negative_comparator_q, negative_comparator_d;
  logic carrier_q, carrier_d;
  logic [1:0] phase_q, phase_d;

  assign high_mode = reference_level > MODE_SPLIT_MV;
  assign release_level = {1'b0, reference_level};
  assign trip_level = {1'b0, reference_level} +
    {1'b0, high_mode ? HYST_HIGH_MV : HYST_LOW_MV};

  always_comb begin
    positive_comparator_d = positive_comparator_q;
    negative_comparator_d = negative_comparator_q;
    // Hysteretic comparison on the magnitude
    if (!input_negative && {1'b0, input_level} > trip_level) begin
      positive_comparator_d = 1'b1;
    end else if (input_negative ||
                 {1'b0, input_level} < release_level) begin
      positive_comparator_d = 1'b0;
    end
    if (high_mode) begin
      negative_comparator_d = 1'b0;
    end else if (input_negative && {1'b0, input_level} > trip_level) begin
      negative_comparator_d = 1'b1;
    end else if (!input_negative ||
                 {1'b0, input_level} < release_level) begin
      negative_comparator_d = 1'b0;
    end
  end

  // Carrier toggles only while the trip is active
  always_comb begin
    phase_d = phase_q;
    carrier_d = carrier_q;
    if (positive_comparator_q || negative_comparator_q) begin
      phase_d = phase_q + 2'h1;
      if (phase_q == 2'(CARRIER_HALF - 1)) begin
        phase_d = 2'h0;
        carrier_d = !carrier_q;
      end
    end else begin
      phase_d = 2'h0;
      carrier_d = 1'b0;
    end
  end

  // Comparators start released so reset gives no false alarm
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      positive_comparator_q <= 1'b0;
      negative_comparator_q <= 1'b0;
    end else if (clk_en) begin
      positive_comparator_q <= positive_comparator_d;
      negative_comparator_q <= negative_comparator_d;
    end
  end

  // Carrier rests low so the receiver reads silence as zero
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      phase_q <= 2'h0;
      carrier_q <= 1'b0;
    end else if (clk_en) begin
      phase_q <= phase_d;
      carrier_q <= carrier_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Low side: receiver, deglitch, latch
  logic rx_trip;
  ook_receiver #(.LOSS(CARRIER_LOSS)) u_rx (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .carrier(carrier_q),
    .bit_out(rx_trip)
  );

  logic [15:0] low_cnt_q, low_cnt_d;
  logic clear_q, clear_d;
  logic latch_q, latch_d;
  logic alarm_q, alarm_d;
  logic clear_now;

  // Clear only after hold_ctrl stays low for the full window
  always_comb begin
    low_cnt_d = low_cnt_q;
    clear_d = clear_q;
    if (hold_ctrl) begin
      low_cnt_d = 16'h0000;
      clear_d = 1'b0;
    end else if (low_cnt_q >= 16'(CLEAR_CNT - 1)) begin
      clear_d = 1'b1;
    end else begin
      low_cnt_d = low_cnt_q + 16'h0001;
    end
  end

  // Short dips restart the count, so noise on hold_ctrl cannot clear
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      low_cnt_q <= 16'h0000;
      clear_q <= 1'b0;
    end else if (clk_en) begin
      low_cnt_q <= low_cnt_d;
      clear_q <= clear_d;
    end
  end

  // Stale clear in the cycle hold_ctrl rises must not drop the latch
  assign clear_now = clear_q && !hold_ctrl;

  // Trip sets latch; set wins over clear
  always_comb begin
    latch_d = latch_q;
    if (rx_trip) begin
      latch_d = 1'b1;
    end else if (clear_now) begin
      latch_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      latch_q <= 1'b0;
    end else if (clk_en) begin
      latch_q <= latch_d;
    end
  end

  // Alarm follows the trip once clear is deglitched, else holds latch
  always_comb begin
    alarm_d = rx_trip;
    if (hold_ctrl) begin
      alarm_d = rx_trip || latch_q;
    end else if (!clear_q) begin
      // Low but not yet deglitched: keep the latched level
      alarm_d = rx_trip || latch_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      alarm_q <= 1'b0;
    end else if (clk_en) begin
      alarm_q <= alarm_d;
    end
  end

  // Open-drain pin: data stays low, the enable carries the alarm
  assign alarm_o = 1'b0;
  assign alarm_oe = alarm_q;
  assign trip_state = rx_trip;
  assign high_hyst_mode = high_mode;
  assign latched = latch_q;
endmodule : trip_latch

// *** rtl/trip_pkg.sv ***
// Purpose: Constants for the isolated trip latch output block
// Assumes: sys_clk at 40 MHz; levels coded in millivolts, unsigned
// Notes: Overview list below names each behaviour kept by the design
//
// Overview of operation
// - Above split level only positive comparator decides
// - Alarm driven low while input exceeds reference
// - Trip at reference plus hysteresis, release below reference
// - Hysteresis 4 mV low range, 25 mV high
// - One sent as carrier burst, zero silent
// - Receiver recovers state from carrier presence
// - Hold-control low gives transparent alarm
// - Transparent alarm releases when input drops
// - Hold-control high gives latch mode
// - Latched alarm stays low after input drops
// - Clear ignored while input above threshold
// - Below split level low-hysteresis mode
package trip_pkg;
  localparam int LEVEL_W = 12;
  // Levels in millivolts
  localparam logic [LEVEL_W-1:0] MODE_SPLIT_MV = 12'h20D; // 525 mV
  localparam logic [LEVEL_W-1:0] HYST_LOW_MV = 12'h004;
  localparam logic [LEVEL_W-1:0] HYST_HIGH_MV = 12'h019;
  localparam logic [LEVEL_W-1:0] REF_MAX_MV = 12'hA8C; // 2700 mV
  localparam int CLK_MHZ = 40;
  localparam int CLEAR_TIME_US = 4;
  localparam int CLEAR_CYCLES = CLEAR_TIME_US * CLK_MHZ;
  // Carrier half period and silence needed to read a zero
  localparam int CARRIER_HALF = 2;
  localparam int CARRIER_LOSS = 8;
endpackage : trip_pkg

// *** test/ctrl_model.sv ***
// Purpose: System controller driving hold control
// Assumes: shares sys_clk with the block
// Notes: bench sets clear pulse length
`timescale 1ns/1ps
module ctrl_model (
  input wire logic sys_clk,
  input wire logic latch_en,
  input wire logic clr_go,
  input wire logic [7:0] clr_len,
  output logic hold_ctrl
);
  logic [7:0] low_q = 8'h00;
  always @(posedge sys_clk) begin
    if (clr_go) begin
      low_q <= clr_len;
    end else if (low_q != 8'h00) begin
      low_q <= low_q - 8'h01;
    end
  end
  // High again after the pulse re-arms latching
  assign hold_ctrl = latch_en && (low_q == 8'h00);
endmodule : ctrl_model

// *** test/tb_top.sv ***
// Purpose: Directed bench for trip_latch
// Assumes: CLEAR_CNT shortened to 4
// Notes: controller model drives hold_ctrl
`timescale 1ns/1ps
module tb_top;
  import trip_pkg::*;
  logic sys_clk = 0, rstn = 0, clk_en = 1, neg = 0, latch_en = 0, go = 0;
  logic [LEVEL_W-1:0] lvl = '0, rfl = 12'h12C, r, h;
  logic [7:0] len = 8'h00;
  logic hold, pin, oe, trip, hhm, lat;
  int failures = 0, n_compared = 0, cyc = 0;
  always #12.5 sys_clk = ~sys_clk;
  trip_latch #(.CLEAR_CNT(4)) i_dut (.sys_clk(sys_clk), .rstn(rstn),
    .clk_en(clk_en), .input_level(lvl), .reference_level(rfl),
    .input_negative(neg), .hold_ctrl(hold), .alarm_o(pin), .alarm_oe(oe),
    .trip_state(trip), .high_hyst_mode(hhm), .latched(lat));
  ctrl_model i_ctrl (.sys_clk(sys_clk), .latch_en(latch_en), .clr_go(go),
    .clr_len(len), .hold_ctrl(hold));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic drive(input logic [11:0] l, input logic n);
    @(posedge sys_clk);
    lvl <= l;
    rfl <= r;
    neg <= n;
    repeat (20) @(posedge sys_clk);
    #1;
  endtask : drive
  task automatic clear(input logic [7:0] n);
    @(posedge sys_clk);
    len <= n;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    repeat (n + 20) @(posedge sys_clk);
    #1;
  endtask : clear
  task automatic end_sim();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 1500) begin
      failures++;
      end_sim();
    end
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    #1;
    chk({oe, lat, trip}, 16'h0);
    chk(pin, 16'h0);
    for (int i = 0; i < 2; i++) begin
      r = i ? 12'h3E8 : 12'h12C;
      h = i ? HYST_HIGH_MV : HYST_LOW_MV;
      // Reference moved only while the input is quiet
      drive(12'h000, 1'b0);
      chk(hhm, 16'(i));
      drive(r + h, 1'b0);
      chk(oe, 16'h0);
      drive(r + h + 12'h001, 1'b0);
      chk({oe, trip}, 16'h3);
      drive(r, 1'b0);
      chk(oe, 16'h1);
      drive(r - 12'h001, 1'b0);
      chk(oe, 16'h0);
      drive(r + 12'h064, 1'b1);
      chk(trip, 16'(i == 0));
      drive(12'h000, 1'b0);
    end
    r = 12'h12C;
    drive(12'h000, 1'b0);
    @(posedge sys_clk) latch_en <= 1'b1;
    drive(12'h136, 1'b0);
    chk(oe, 16'h1);
    drive(12'h000, 1'b0);
    chk({oe, lat}, 16'h3);
    clear(8'h03);
    chk(oe, 16'h1);
    drive(12'h136, 1'b0);
    clear(8'h0A);
    chk(oe, 16'h1);
    drive(12'h000, 1'b0);
    chk(oe, 16'h1);
    clear(8'h0A);
    chk({oe, lat}, 16'h0);
    // Frozen clock enable: a trip must not pass until enabled
    @(posedge sys_clk) clk_en <= 1'b0;
    drive(12'h136, 1'b0);
    chk({oe, trip}, 16'h0);
    @(posedge sys_clk) clk_en <= 1'b1;
    repeat (20) @(posedge sys_clk);
    #1;
    chk({oe, lat}, 16'h3);
    end_sim();
  end
endmodule : tb_top

// *** test/trip_latch_monitor.sv ***
// Purpose: Port checks for trip_latch
// Assumes: checks paused while clk_en is low
// Notes: bound below
`timescale 1ns/1ps
module trip_latch_monitor
  import trip_pkg::*;
#(parameter int CLEAR_CNT = CLEAR_CYCLES) (
  input wire logic sys_clk, rstn, clk_en, input_negative, hold_ctrl,
  input wire logic [LEVEL_W-1:0] input_level, reference_level,
  input wire logic alarm_o, alarm_oe, trip_state, high_hyst_mode, latched
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn || !clk_en);
  sequence s_over;
    (!input_negative && input_level > reference_level + HYST_HIGH_MV)[*8];
  endsequence
  sequence s_under;
    (input_level < reference_level)[*8];
  endsequence
  a_mode_flag: assert property (
    high_hyst_mode == (reference_level > MODE_SPLIT_MV)) else $error("mode");
  a_pin_low: assert property (!alarm_o) else $error("pin");
  a_trip_rise: assert property (
    s_over |-> ##[0:6] trip_state) else $error("no trip");
  a_trip_fall: assert property (
    s_under |-> ##[0:8] !trip_state) else $error("no release");
  a_trip_alarm: assert property (
    trip_state |=> alarm_oe) else $error("alarm late");
  a_free_release: assert property (
    !latched && !trip_state |=> !alarm_oe) else $error("alarm stuck");
  a_latch_keep: assert property (
    hold_ctrl && alarm_oe |=> alarm_oe) else $error("latch lost");
  a_short_low: assert property (
    $fell(hold_ctrl) && latched |-> latched[*4]) else $error("glitch");
endmodule : trip_latch_monitor
bind trip_latch trip_latch_monitor #(.CLEAR_CNT(CLEAR_CNT)) i_mon (
  .sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .hold_ctrl(hold_ctrl),
  .input_negative(input_negative), .input_level(input_level),
  .reference_level(reference_level), .alarm_o(alarm_o), .latched(latched),
  .alarm_oe(alarm_oe), .trip_state(trip_state),
  .high_hyst_mode(high_hyst_mode));
